/* File: hdl/rbl_readout_map.sv */
// host map of readout fifos, region record ram and energy lookup tables
//
// Notes on behaviour
// - The crate fifos hold input and output records laid out as the crate record rams.
// - The system input and output fifos hold records laid out exactly as the system record rams.
// - A scrolling dual-port region output ram records each region record for host reads.
// - Third region bank: X bit 16 at bit 0, Y bit 16 at bit 1, total hits 4-7, missing 8-15.
// - The region fifo buffers region output records with the same layout as the region ram.
// - The main jet table turns main jet hit counts into energies ahead of any threshold compare.
// - Each main jet table word holds thresholds 1-4 in the low byte and 5-8 in the high byte.
// - Forward jet words keep only the low byte; the high byte is dropped on write, reads zero.
// - A missing energy table maps missing transverse energy onto threshold hit bits.
// - The lower 4096 missing energy words hold table 0 in the low byte and table 1 high.
// - The upper 4096 words from byte offset 0x2000 hold table 2 in the low byte and table 3 high.
// - A crate input record is 25 bits plus parity, split over two host words, low bits first.
`timescale 1ns/10ps
module rbl_readout_map
	import rbl_pkg::*;
#(
	parameter int RDO_DEPTH = 4,
	parameter int JCNT_W    = 8,
	parameter int MET_W     = 12
)
(
	// clock and reset
	input  wire logic            mclk_i,
	input  wire logic            reset_n_i,
	// host word access
	input  wire rbl_host_req_t   host_req_i,
	output rbl_host_rsp_t        host_rsp_o,
	// crate input record stream
	input  wire logic            crate_in_valid_i,
	input  wire rbl_crate_in_t   crate_in_rec_i,
	output logic                 crate_in_ready_o,
	// crate output record stream
	input  wire logic            crate_out_valid_i,
	input  wire logic [ENT_W-1:0] crate_out_words_i,
	output logic                 crate_out_ready_o,
	// system input record stream
	input  wire logic            sys_in_valid_i,
	input  wire logic [ENT_W-1:0] sys_in_words_i,
	output logic                 sys_in_ready_o,
	// system output record stream
	input  wire logic            sys_out_valid_i,
	input  wire logic [ENT_W-1:0] sys_out_words_i,
	output logic                 sys_out_ready_o,
	// region output record stream
	input  wire logic            region_valid_i,
	input  wire rbl_region_rec_t region_rec_i,
	output logic                 region_ready_o,
	// real-time lookups
	input  wire logic [JCNT_W-1:0] main_jet_count_i,
	output logic [HD_W-1:0]      main_jet_energy_o,
	input  wire logic [JCNT_W-1:0] fwd_jet_count_i,
	output logic [BYTE_W-1:0]    fwd_jet_energy_o,
	input  wire logic [1:0]      met_range_i,
	input  wire logic [MET_W-1:0] met_value_i,
	output logic [BYTE_W-1:0]    met_hits_o
);

	// host decode
	rbl_target_t           tgt;
	logic [HA_W-1:0]       ofs;
	logic [WIX_W-1:0]      widx;
	logic                  rd_hit;
	logic                  wr_hit;
	logic [RDO_ID_W-1:0]   rdo_id;
	logic [RDO_WORD_W-1:0] rdo_word;
	logic [HD_W-1:0]       rdo_rdata;

	// readout fifo wiring
	logic [NUM_RDO-1:0]    push_valid;
	logic [NUM_RDO-1:0]    push_ready;
	logic [NUM_RDO-1:0]    pop_valid;
	logic [NUM_RDO-1:0]    pop_ready;
	logic [ENT_W-1:0]      push_data [NUM_RDO];
	logic [ENT_W-1:0]      pop_data  [NUM_RDO];

	// tables and region record ram
	logic [BYTE_W-1:0]     mj_lo_q  [MJ_DEPTH];
	logic [BYTE_W-1:0]     mj_hi_q  [MJ_DEPTH];
	logic [BYTE_W-1:0]     fj_q     [FJ_DEPTH];
	logic [BYTE_W-1:0]     met_lo_q [MET_DEPTH];
	logic [BYTE_W-1:0]     met_hi_q [MET_DEPTH];
	logic [HD_W-1:0]       rram_q   [RRAM_BANKS][RRAM_DEPTH];
	logic [RRAM_IX_W-1:0]  rram_wptr_q;
	logic [ENT_W-1:0]      region_words;
	logic                  region_fire;
	logic [WIX_W-1:0]      met_rt_idx;

	// host response registers
	logic                  ack_q;
	logic [HD_W-1:0]       rdata_q;

	// real-time result registers
	logic [HD_W-1:0]       mj_energy_q;
	logic [BYTE_W-1:0]     fj_energy_q;
	logic [BYTE_W-1:0]     met_hits_q;

	assign tgt      = rbl_decode(host_req_i.addr);
	assign ofs      = host_req_i.addr - rbl_base(tgt);
	// byte lane 0 of the address is ignored: every access is a whole 16-bit word
	assign widx     = ofs[WIX_W:1];
	assign rd_hit   = host_req_i.rd;
	assign wr_hit   = host_req_i.wr & ~host_req_i.rd;
	assign rdo_id   = widx[RDO_ID_W+RDO_WORD_W-1:RDO_WORD_W];
	assign rdo_word = widx[RDO_WORD_W-1:0];

	// record streams into the readout fifos
	assign region_words = rbl_region_words(region_rec_i);
	assign push_valid[RDO_CRATE_IN]  = crate_in_valid_i;
	assign push_data[RDO_CRATE_IN]   = rbl_crate_in_words(crate_in_rec_i);
	assign push_valid[RDO_CRATE_OUT] = crate_out_valid_i;
	assign push_data[RDO_CRATE_OUT]  = crate_out_words_i;
	assign push_valid[RDO_SYS_IN]    = sys_in_valid_i;
	assign push_data[RDO_SYS_IN]     = sys_in_words_i;
	assign push_valid[RDO_SYS_OUT]   = sys_out_valid_i;
	assign push_data[RDO_SYS_OUT]    = sys_out_words_i;
	assign push_valid[RDO_REGION]    = region_valid_i;
	assign push_data[RDO_REGION]     = region_words;

	// a full fifo stalls its producer rather than dropping records
	assign crate_in_ready_o  = push_ready[RDO_CRATE_IN];
	assign crate_out_ready_o = push_ready[RDO_CRATE_OUT];
	assign sys_in_ready_o    = push_ready[RDO_SYS_IN];
	assign sys_out_ready_o   = push_ready[RDO_SYS_OUT];
	assign region_ready_o    = push_ready[RDO_REGION];

	// the region ram scrolls only with records the fifo also took, so both stay aligned
	assign region_fire = region_valid_i & push_ready[RDO_REGION];

	genvar g;
	generate
		for (g = 0; g < NUM_RDO; g++)
		begin : g_rdo
			// pop only on the last word of an entry that is actually there
			assign pop_ready[g] = rd_hit && (tgt == TGT_RDO) && (rdo_id == RDO_ID_W'(g))
				&& (rdo_word == RDO_LAST_WORD[g]);

			rbl_fifo
			#(
				.WIDTH (ENT_W),
				.DEPTH (RDO_DEPTH)
			)
			u_fifo
			(
				.mclk_i      (mclk_i),
				.reset_n_i   (reset_n_i),
				.in_valid_i  (push_valid[g]),
				.in_ready_o  (push_ready[g]),
				.in_data_i   (push_data[g]),
				.out_valid_o (pop_valid[g]),
				.out_ready_i (pop_ready[g]),
				.out_data_o  (pop_data[g])
			);
		end
	endgenerate

	// head word of the addressed fifo; an empty fifo or an unused word reads zero
	always_comb
	begin
		rdo_rdata = '0;
		for (int i = 0; i < NUM_RDO; i++)
		begin
			if ((rdo_id == RDO_ID_W'(i)) && pop_valid[i] && (rdo_word <= RDO_LAST_WORD[i]))
				rdo_rdata = pop_data[i][rdo_word[1:0]*HD_W +: HD_W];
		end
	end

	// scrolling region record ram: overwrites the oldest record once it wraps
	always_ff @(posedge mclk_i)
	begin
		if (region_fire)
		begin
			for (int b = 0; b < RRAM_BANKS; b++)
				rram_q[b][rram_wptr_q] <= region_words[b*HD_W +: HD_W];
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			rram_wptr_q <= '0;
		else if (region_fire)
			rram_wptr_q <= rram_wptr_q + 1'b1;
	end

	// main jet table writes
	always_ff @(posedge mclk_i)
	begin
		if (wr_hit && (tgt == TGT_MJ))
		begin
			mj_lo_q[widx[JCNT_W-1:0]] <= host_req_i.wdata[BYTE_W-1:0];
			mj_hi_q[widx[JCNT_W-1:0]] <= host_req_i.wdata[HD_W-1:BYTE_W];
		end
	end

	// forward jet table writes keep the low byte only
	always_ff @(posedge mclk_i)
	begin
		if (wr_hit && (tgt == TGT_FJ))
			fj_q[widx[JCNT_W-1:0]] <= host_req_i.wdata[BYTE_W-1:0];
	end

	// missing energy table writes; word index bit 12 is the 0x2000 byte boundary
	always_ff @(posedge mclk_i)
	begin
		if (wr_hit && (tgt == TGT_MET))
		begin
			met_lo_q[widx] <= host_req_i.wdata[BYTE_W-1:0];
			met_hi_q[widx] <= host_req_i.wdata[HD_W-1:BYTE_W];
		end
	end

	// host read data and acknowledge, one cycle after the strobe
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			ack_q   <= 1'b0;
			rdata_q <= '0;
		end
		else
		begin
			ack_q <= host_req_i.rd | host_req_i.wr;
			if (rd_hit)
			begin
				unique case (tgt)
					TGT_RDO:
						rdata_q <= rdo_rdata;
					TGT_MJ:
						rdata_q <= {mj_hi_q[widx[JCNT_W-1:0]], mj_lo_q[widx[JCNT_W-1:0]]};
					TGT_FJ:
						rdata_q <= {{(HD_W-BYTE_W){1'b0}}, fj_q[widx[JCNT_W-1:0]]};
					TGT_MET:
						rdata_q <= {met_hi_q[widx], met_lo_q[widx]};
					TGT_RRAM:
						rdata_q <= rram_q[widx[RRAM_BANK_W+RRAM_IX_W-1:RRAM_IX_W]]
							[widx[RRAM_IX_W-1:0]];
					TGT_NONE:
						rdata_q <= '0;
				endcase
			end
			else
			begin
				rdata_q <= '0;
			end
		end
	end

	assign host_rsp_o.ack   = ack_q;
	assign host_rsp_o.rdata = rdata_q;

	// range 0/1 use the lower half, 2/3 the upper; odd ranges take the high byte
	assign met_rt_idx = {met_range_i[1], met_value_i};

	// real-time lookups; energies come out before any threshold stage sees them
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			mj_energy_q <= '0;
			fj_energy_q <= '0;
			met_hits_q  <= '0;
		end
		else
		begin
			mj_energy_q <= {mj_hi_q[main_jet_count_i], mj_lo_q[main_jet_count_i]};
			fj_energy_q <= fj_q[fwd_jet_count_i];
			if (met_range_i[0])
				met_hits_q <= met_hi_q[met_rt_idx];
			else
				met_hits_q <= met_lo_q[met_rt_idx];
		end
	end

	assign main_jet_energy_o = mj_energy_q;
	assign fwd_jet_energy_o  = fj_energy_q;
	assign met_hits_o        = met_hits_q;

endmodule

/* File: hdl/rbl_pkg.sv */
// package: host address map, record layouts and table sizes for the readout buffer and table map
package rbl_pkg;

	// host bus geometry (16-bit words, byte addresses)
	localparam int HA_W   = 17;
	localparam int HD_W   = 16;
	localparam int BYTE_W = 8;
	localparam int WIX_W  = 13;

	// readout fifos
	localparam int NUM_RDO      = 5;
	localparam int ENT_W        = 64;
	localparam int RDO_ID_W     = 3;
	localparam int RDO_WORD_W   = 3;
	localparam int RDO_CRATE_IN = 0;
	localparam int RDO_CRATE_OUT = 1;
	localparam int RDO_SYS_IN   = 2;
	localparam int RDO_SYS_OUT  = 3;
	localparam int RDO_REGION   = 4;
	localparam logic [RDO_WORD_W-1:0] RDO_LAST_WORD [NUM_RDO] =
		'{3'h1, 3'h2, 3'h3, 3'h3, 3'h3};

	// address windows
	localparam logic [HA_W-1:0] ADDR_MJ_BASE   = 17'h04000;
	localparam logic [HA_W-1:0] ADDR_MJ_SIZE   = 17'h00200;
	localparam logic [HA_W-1:0] ADDR_FJ_BASE   = 17'h04400;
	localparam logic [HA_W-1:0] ADDR_FJ_SIZE   = 17'h00200;
	localparam logic [HA_W-1:0] ADDR_RRAM_BASE = 17'h04800;
	localparam logic [HA_W-1:0] ADDR_RRAM_SIZE = 17'h00800;
	localparam logic [HA_W-1:0] ADDR_RDO_BASE  = 17'h05000;
	localparam logic [HA_W-1:0] ADDR_RDO_SIZE  = 17'h00050;
	localparam logic [HA_W-1:0] ADDR_MET_BASE  = 17'h08000;
	localparam logic [HA_W-1:0] ADDR_MET_SIZE  = 17'h04000;
	localparam logic [HA_W-1:0] MET_UPPER_OFS  = 17'h02000;

	// table and record ram sizes
	localparam int MJ_DEPTH       = 256;
	localparam int FJ_DEPTH       = 256;
	localparam int MET_HALF_DEPTH = 4096;
	localparam int MET_DEPTH      = 2 * MET_HALF_DEPTH;
	localparam int RRAM_DEPTH     = 256;
	localparam int RRAM_BANKS     = 4;
	localparam int RRAM_IX_W      = 8;
	localparam int RRAM_BANK_W    = 2;

	// third region bank layout
	localparam int B2_EX16    = 0;
	localparam int B2_EY16    = 1;
	localparam int B2_ETH_LO  = 4;
	localparam int B2_ETH_HI  = 7;
	localparam int B2_MISS_LO = 8;
	localparam int B2_MISS_HI = 15;

	// crate input record: 25 data bits plus parity flag in the upper word
	localparam int CI_DATA_W  = 25;
	localparam int CI_UP_W    = CI_DATA_W - HD_W;
	localparam int CI_PAR_POS = 9;

	typedef enum logic [5:0] {
		TGT_NONE = 6'h01,
		TGT_RDO  = 6'h02,
		TGT_MJ   = 6'h04,
		TGT_FJ   = 6'h08,
		TGT_MET  = 6'h10,
		TGT_RRAM = 6'h20
	} rbl_target_t;

	typedef struct packed {
		logic            rd;
		logic            wr;
		logic [HA_W-1:0] addr;
		logic [HD_W-1:0] wdata;
	} rbl_host_req_t;

	typedef struct packed {
		logic            ack;
		logic [HD_W-1:0] rdata;
	} rbl_host_rsp_t;

	typedef struct packed {
		logic                 parity_err;
		logic [CI_DATA_W-1:0] data;
	} rbl_crate_in_t;

	typedef struct packed {
		logic [HD_W:0]   ex;
		logic [HD_W:0]   ey;
		logic [HD_W-1:0] et;
		logic [3:0]      et_hits;
		logic [7:0]      miss_hits;
	} rbl_region_rec_t;

	function automatic logic rbl_in(input logic [HA_W-1:0] a, input logic [HA_W-1:0] base,
		input logic [HA_W-1:0] size);
		return (a >= base) && (a < base + size);
	endfunction

	function automatic rbl_target_t rbl_decode(input logic [HA_W-1:0] a);
		if (rbl_in(a, ADDR_MET_BASE, ADDR_MET_SIZE))
			return TGT_MET;
		if (rbl_in(a, ADDR_MJ_BASE, ADDR_MJ_SIZE))
			return TGT_MJ;
		if (rbl_in(a, ADDR_FJ_BASE, ADDR_FJ_SIZE))
			return TGT_FJ;
		if (rbl_in(a, ADDR_RRAM_BASE, ADDR_RRAM_SIZE))
			return TGT_RRAM;
		if (rbl_in(a, ADDR_RDO_BASE, ADDR_RDO_SIZE))
			return TGT_RDO;
		return TGT_NONE;
	endfunction

	function automatic logic [HA_W-1:0] rbl_base(input rbl_target_t t);
		unique case (t)
			TGT_MET:  return ADDR_MET_BASE;
			TGT_MJ:   return ADDR_MJ_BASE;
			TGT_FJ:   return ADDR_FJ_BASE;
			TGT_RRAM: return ADDR_RRAM_BASE;
			TGT_RDO:  return ADDR_RDO_BASE;
			TGT_NONE: return '0;
		endcase
	endfunction

	function automatic logic [ENT_W-1:0] rbl_region_words(input rbl_region_rec_t r);
		logic [HD_W-1:0] b2;
		b2 = '0;
		b2[B2_EX16] = r.ex[HD_W];
		b2[B2_EY16] = r.ey[HD_W];
		b2[B2_ETH_HI:B2_ETH_LO] = r.et_hits;
		b2[B2_MISS_HI:B2_MISS_LO] = r.miss_hits;
		return {r.et, b2, r.ey[HD_W-1:0], r.ex[HD_W-1:0]};
	endfunction

	function automatic logic [ENT_W-1:0] rbl_crate_in_words(input rbl_crate_in_t c);
		logic [HD_W-1:0] up;
		up = '0;
		up[CI_UP_W-1:0] = c.data[CI_DATA_W-1:HD_W];
		up[CI_PAR_POS] = c.parity_err;
		return {{(ENT_W-2*HD_W){1'b0}}, up, c.data[HD_W-1:0]};
	endfunction

endpackage

/* File: hdl/rbl_fifo.sv */
// small first-word-fall-through fifo with valid/ready on both sides
`timescale 1ns/10ps
module rbl_fifo
#(
	parameter int WIDTH = 64,
	parameter int DEPTH = 4
)
(
	// clock and reset
	input  wire logic             mclk_i,
	input  wire logic             reset_n_i,
	// fill side
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// drain side
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0]    wr_ptr_q;
	logic [PW-1:0]    rd_ptr_q;
	logic [PW:0]      count_q;
	logic             push;
	logic             pop;

	assign in_ready_o  = count_q != (PW+1)'(DEPTH);
	assign out_valid_o = count_q != '0;
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;
	assign out_data_o  = mem_q[rd_ptr_q];

	function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
		return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
	endfunction

	always_ff @(posedge mclk_i)
	begin
		if (push)
			mem_q[wr_ptr_q] <= in_data_i;
	end

	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_q <= bump(wr_ptr_q);
			if (pop)
				rd_ptr_q <= bump(rd_ptr_q);
			// simultaneous push and pop leave the fill level unchanged
			if (push && !pop)
				count_q <= count_q + 1'b1;
			else if (pop && !push)
				count_q <= count_q - 1'b1;
		end
	end
endmodule

/* File: verification/rbl_readout_map_chk.sv */
// checker: host answer timing, table read-back and lookup relations
`timescale 1ns/10ps
module rbl_readout_map_chk
	import rbl_pkg::*;
(
	// clock and reset
	input  wire logic            mclk_i,
	input  wire logic            reset_n_i,
	// host port
	input  wire rbl_host_req_t   host_req_i,
	input  wire rbl_host_rsp_t   host_rsp_o,
	// lookups
	input  wire logic [7:0]      main_jet_count_i,
	input  wire logic [HD_W-1:0] main_jet_energy_o,
	input  wire logic [7:0]      fwd_jet_count_i,
	input  wire logic [7:0]      fwd_jet_energy_o,
	input  wire logic [1:0]      met_range_i,
	input  wire logic [11:0]     met_value_i,
	input  wire logic [7:0]      met_hits_o
);
	// last cycle's pure write, so read-back and lookups can be tied to it
	logic            pw_q;
	logic [HA_W-1:0] pa_q;
	logic [HD_W-1:0] pd_q;
	logic            mj;
	logic            fj;
	logic            met;
	logic            rd_same;
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			pw_q <= 1'b0;
		else
			pw_q <= host_req_i.wr && !host_req_i.rd;
	end
	// data and address need no reset: only used while pw_q is set
	always_ff @(posedge mclk_i)
	begin
		pa_q <= host_req_i.addr;
		pd_q <= host_req_i.wdata;
	end
	assign mj = pw_q && pa_q[16:9] == 8'h20;
	assign fj = pw_q && pa_q[16:9] == 8'h22;
	assign met = pw_q && pa_q[16:14] == 3'b010;
	assign rd_same = host_req_i.rd && host_req_i.addr[16:1] == pa_q[16:1];
	sequence s_req;
		host_req_i.rd || host_req_i.wr;
	endsequence
	sequence s_mj_look;
		mj && main_jet_count_i == pa_q[8:1];
	endsequence
	sequence s_fj_look;
		fj && fwd_jet_count_i == pa_q[8:1];
	endsequence
	sequence s_met_look;
		met && met_range_i[1] == pa_q[13] && met_value_i == pa_q[12:1];
	endsequence
	a_ack_follows_req: assert property (s_req |=> host_rsp_o.ack)
		else $error("no answer one cycle after a host request");
	a_no_spurious_ack: assert property (!host_req_i.rd && !host_req_i.wr |=> !host_rsp_o.ack)
		else $error("answer without a host request");
	a_idle_rdata_zero: assert property (!host_rsp_o.ack |-> host_rsp_o.rdata == '0)
		else $error("read data not zero outside an answer");
	a_mj_word_back: assert property (mj && rd_same |=> host_rsp_o.rdata == $past(pd_q))
		else $error("main jet word not read back whole");
	a_fj_low_back: assert property (fj && rd_same
		|=> host_rsp_o.rdata == {8'h00, $past(pd_q[7:0])})
		else $error("forward jet word read back wrong");
	a_fj_high_zero: assert property (host_req_i.rd && host_req_i.addr[16:9] == 8'h22
		|=> host_rsp_o.rdata[15:8] == 8'h00)
		else $error("forward jet high byte not zero");
	a_met_word_back: assert property (met && rd_same |=> host_rsp_o.rdata == $past(pd_q))
		else $error("missing energy word read back wrong");
	a_mj_lookup_new: assert property (s_mj_look |=> main_jet_energy_o == $past(pd_q))
		else $error("main jet lookup misses fresh entry");
	a_fj_lookup_new: assert property (s_fj_look |=> fwd_jet_energy_o == $past(pd_q[7:0]))
		else $error("forward jet lookup misses fresh entry");
	a_met_lookup_new: assert property (s_met_look
		|=> met_hits_o == ($past(met_range_i[0]) ? $past(pd_q[15:8]) : $past(pd_q[7:0])))
		else $error("missing energy lookup picks wrong table");
endmodule
bind rbl_readout_map rbl_readout_map_chk chk (.mclk_i, .reset_n_i, .host_req_i, .host_rsp_o,
	.main_jet_count_i, .main_jet_energy_o, .fwd_jet_count_i, .fwd_jet_energy_o, .met_range_i,
	.met_value_i, .met_hits_o);

/* File: verification/rbl_host_model.sv */
// host bus master model: word reads and writes on the block's host port
`timescale 1ns/10ps
module rbl_host_model
	import rbl_pkg::*;
(
	// clock
	input  wire logic          mclk_i,
	// host port
	output rbl_host_req_t      host_req_o,
	input  wire rbl_host_rsp_t host_rsp_i
);
	initial host_req_o = '0;
	// one pulse per call; idle address and data flip so stale values never look valid
	task automatic acc(input logic rd, input logic wr, input logic [HA_W-1:0] a,
		input logic [HD_W-1:0] d, output rbl_host_rsp_t r);
		@(posedge mclk_i);
		#1 host_req_o = '{rd, wr, a, d};
		@(posedge mclk_i);
		#1 host_req_o = '{1'b0, 1'b0, ~a, ~d};
		r = host_rsp_i;
	endtask
	// write then read of the same word on consecutive edges
	task automatic wrrd(input logic [HA_W-1:0] a, input logic [HD_W-1:0] d,
		output rbl_host_rsp_t rw, output rbl_host_rsp_t rr);
		@(posedge mclk_i);
		#1 host_req_o = '{1'b0, 1'b1, a, d};
		@(posedge mclk_i);
		#1 host_req_o = '{1'b1, 1'b0, a, ~d};
		rw = host_rsp_i;
		@(posedge mclk_i);
		#1 host_req_o = '{1'b0, 1'b0, ~a, d};
		rr = host_rsp_i;
	endtask
endmodule

/* File: verification/tb_readout_buffer_lut_map.sv */
// testbench: host reads and writes of readout fifos and lookup tables, host reads of region ram
`timescale 1ns/10ps
module tb_readout_buffer_lut_map;
	import rbl_pkg::*;
	logic          mclk_i = 1'b0;
	logic          reset_n_i = 1'b0;
	rbl_host_req_t hreq;
	rbl_host_rsp_t hrsp;
	rbl_host_rsp_t rw;
	rbl_host_rsp_t rr;
	logic [4:0]    vld = '0;
	logic [4:0]    rdy;
	logic [63:0]   wd = '0;
	logic [7:0]    mjc = 8'h05;
	logic [7:0]    fjc = 8'h07;
	logic [1:0]    mr = '0;
	logic [11:0]   mv = 12'h003;
	logic [15:0]   mje;
	logic [7:0]    fje;
	logic [7:0]    mh;
	int            err_total = 0;
	int            checks = 0;
	logic [7:0]    met_exp [4] = '{8'h34, 8'h12, 8'h78, 8'h56};
	logic [15:0]   reg_exp [4] = '{16'h2345, 16'h6789, 16'hc393, 16'hcafe};
	always #2 mclk_i = ~mclk_i;
	rbl_host_model host (.mclk_i(mclk_i), .host_req_o(hreq), .host_rsp_i(hrsp));
	rbl_readout_map uut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .host_req_i(hreq),
		.host_rsp_o(hrsp), .crate_in_valid_i(vld[0]),
		.crate_in_rec_i(rbl_crate_in_t'(wd[25:0])), .crate_in_ready_o(rdy[0]),
		.crate_out_valid_i(vld[1]), .crate_out_words_i(wd), .crate_out_ready_o(rdy[1]),
		.sys_in_valid_i(vld[2]), .sys_in_words_i(wd), .sys_in_ready_o(rdy[2]),
		.sys_out_valid_i(vld[3]), .sys_out_words_i(wd), .sys_out_ready_o(rdy[3]),
		.region_valid_i(vld[4]), .region_rec_i(rbl_region_rec_t'(wd[61:0])),
		.region_ready_o(rdy[4]), .main_jet_count_i(mjc), .main_jet_energy_o(mje),
		.fwd_jet_count_i(fjc), .fwd_jet_energy_o(fje), .met_range_i(mr),
		.met_value_i(mv), .met_hits_o(mh));
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// an answer that is missing turns into a mismatch through the flipped fallback
	task automatic rdw(input logic [HA_W-1:0] a, input logic [15:0] exp);
		host.acc(1'b1, 1'b0, a, '0, rr);
		chk(rr.ack ? rr.rdata : ~exp, exp);
	endtask
	task automatic tbl(input logic [HA_W-1:0] a, input logic [15:0] d, input logic [15:0] exp);
		host.wrrd(a, d, rw, rr);
		chk(rw.ack ? rw.rdata : 16'hffff, 16'h0000);
		chk(rr.ack ? rr.rdata : ~exp, exp);
	endtask
	task automatic push(input int i, input logic [63:0] w);
		@(posedge mclk_i);
		#1 wd = w;
		vld[i] = 1'b1;
		chk({15'h0, rdy[i]}, 16'h0001);
		@(posedge mclk_i);
		#1 vld[i] = 1'b0;
	endtask
	initial
	begin
		#80000;
		err_total++;
		tally_and_finish();
	end
	initial
	begin
		repeat (8) @(posedge mclk_i);
		#1 reset_n_i = 1'b1;
		chk(hrsp.rdata, 16'h0000);
		tbl(ADDR_MJ_BASE + 17'h0000a, 16'ha55a, 16'ha55a);
		chk(mje, 16'ha55a);
		tbl(ADDR_FJ_BASE + 17'h0000e, 16'hbeef, 16'h00ef);
		chk({8'h00, fje}, 16'h00ef);
		tbl(ADDR_MET_BASE + 17'h00006, 16'h1234, 16'h1234);
		tbl(ADDR_MET_BASE + MET_UPPER_OFS + 17'h00006, 16'h5678, 16'h5678);
		for (int r = 0; r < 4; r++)
		begin
			@(posedge mclk_i);
			#1 mr = 2'(r);
			@(posedge mclk_i);
			#1 chk({8'h00, mh}, {8'h00, met_exp[r]});
		end
		// fill the crate input fifo until it refuses, then drain it in order
		for (int k = 0; k < 4; k++)
			push(RDO_CRATE_IN, {38'h0, 1'b1, 25'h1abcde0 + 25'(k)});
		chk({15'h0, rdy[0]}, 16'h0000);
		rdw(ADDR_RDO_BASE, 16'hcde0);
		for (int k = 0; k < 4; k++)
		begin
			rdw(ADDR_RDO_BASE, 16'hcde0 + 16'(k));
			rdw(ADDR_RDO_BASE + 17'h2, 16'h03ab);
		end
		rdw(ADDR_RDO_BASE, 16'h0000);
		chk({15'h0, rdy[0]}, 16'h0001);
		push(RDO_REGION, {2'b0, 17'h12345, 17'h16789, 16'hcafe, 4'h9, 8'hc3});
		rdw(ADDR_RRAM_BASE + 17'h400, 16'hc393);
		rdw(ADDR_RRAM_BASE + 17'h600, 16'hcafe);
		for (int n = 0; n < 4; n++)
			rdw(ADDR_RDO_BASE + 17'h40 + 17'(2 * n), reg_exp[n]);
		// a second record must land one slot further on without disturbing the first
		push(RDO_REGION, {2'b0, 17'h0, 17'h0, 16'h1357, 4'h0, 8'h00});
		rdw(ADDR_RRAM_BASE + 17'h602, 16'h1357);
		rdw(ADDR_RRAM_BASE + 17'h600, 16'hcafe);
		for (int i = 1; i < 4; i++)
		begin
			push(i, 64'h4444_3333_2222_1111);
			for (int n = 0; n < 4; n++)
				rdw(ADDR_RDO_BASE + 17'(16 * i + 2 * n),
					(i == 1 && n == 3) ? 16'h0 : 16'h1111 * 16'(n + 1));
		end
		host.acc(1'b0, 1'b1, ADDR_RDO_BASE, 16'hffff, rw);
		chk(rw.ack ? rw.rdata : 16'hffff, 16'h0000);
		rdw(ADDR_RDO_BASE, 16'h0000);
		rdw(17'h1fff0, 16'h0000);
		tally_and_finish();
	end
endmodule
